//--- src/urm_pkg.sv
package urm_pkg;
  // Register indices on the three address lines
  localparam logic [2:0] URM_ADDR_DATA = 3'h0;
  localparam logic [2:0] URM_ADDR_IEN = 3'h1;
  localparam logic [2:0] URM_ADDR_ISTF = 3'h2;
  localparam logic [2:0] URM_ADDR_LCTL = 3'h3;
  localparam logic [2:0] URM_ADDR_MCTL = 3'h4;
  localparam logic [2:0] URM_ADDR_LSTS = 3'h5;
  localparam logic [2:0] URM_ADDR_MSTS = 3'h6;
  localparam logic [2:0] URM_ADDR_SCR = 3'h7;
  // Line control value that opens the enhanced bank
  localparam logic [7:0] URM_ENH_KEY = 8'hBF;
  // Field positions
  localparam int URM_LCR_DIVEN_BIT = 7;
  localparam int URM_MCR_LOOP_BIT = 4;
  localparam int URM_MCR_RTS_BIT = 1;
  localparam int URM_EFR_ENH_BIT = 4;
  // Masks of bits that need the enhanced enable
  localparam logic [7:0] URM_IER_ENH_MASK = 8'hF0;
  localparam logic [7:0] URM_ISR_ENH_MASK = 8'h30;
  localparam logic [7:0] URM_FCR_ENH_MASK = 8'h30;
  localparam logic [7:0] URM_MCR_ENH_MASK = 8'hE4;
  // Values after reset
  localparam logic [7:0] URM_RST_BYTE = 8'h00;
  localparam logic [7:0] URM_RST_LCR = 8'h03;
  localparam logic [15:0] URM_RST_DIV = 16'h0001;
  // Status values without the receive and transmit engines
  localparam logic [7:0] URM_ISR_NONE = 8'h01;
  localparam logic [7:0] URM_LSR_RDY = 8'h01;
  localparam logic [7:0] URM_LSR_TXE = 8'h60;
  // Serial frame length in bit times, start plus eight data plus stop
  localparam logic [3:0] URM_FRAME_BITS = 4'hA;
  localparam logic [3:0] URM_OVERSAMPLE = 4'hF;

  // Host bus request
  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } urm_bus_type;

  // Modem-side input levels, already synchronised
  typedef struct packed {
    logic cd;
    logic ri;
    logic dsr;
    logic cts;
  } urm_modem_type;
endpackage

//--- src/urm_sync.sv
`timescale 1ns/10ps
`default_nettype none
// Three-stage synchroniser with agreement filter on the last two stages
module urm_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '1
) (
  input wire logic clk_in, // System clock
  input wire logic rst_in, // Synchronous reset
  input wire logic [WIDTH-1:0] async_in, // Raw pin levels
  output logic [WIDTH-1:0] level_out // Filtered level
);
  import urm_pkg::*;
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;
  logic [WIDTH-1:0] lvl_reg;
  wire logic [WIDTH-1:0] agree = ~(s2_reg ^ s3_reg);
  wire logic [WIDTH-1:0] lvl_next = (agree & s3_reg) | (~agree & lvl_reg);
  // Shift chain and filtered level
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      lvl_reg <= INIT;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      lvl_reg <= lvl_next;
    end
  end
  assign level_out = lvl_reg;
endmodule // urm_sync
`default_nettype wire

//--- src/urm_serial.sv
`timescale 1ns/10ps
`default_nettype none
// Minimal 8N1 shifter pair: transmit and receive shift registers
module urm_serial (
  input wire logic clk_in, // System clock
  input wire logic rst_in, // Synchronous reset
  input wire logic [15:0] divisor_in, // Baud divisor
  input wire logic tx_load_in, // Load transmit byte
  input wire logic [7:0] tx_byte_in, // Transmit byte
  input wire logic rx_line_in, // Receive shift input
  output logic tx_line_out, // Transmit shift output
  output logic tx_busy_out, // Shifter busy
  output logic rx_done_out, // Byte received pulse
  output logic [7:0] rx_byte_out, // Received byte
  output logic rx_break_out // Line held low a whole frame
);
  import urm_pkg::*;
  logic [15:0] brg_reg;
  logic [3:0] tx_sub_reg;
  logic [3:0] tx_cnt_reg;
  logic [9:0] tx_sh_reg;
  logic [3:0] rx_sub_reg;
  logic [3:0] rx_cnt_reg;
  logic [8:0] rx_sh_reg;
  logic rx_act_reg;
  logic rx_done_reg;
  logic rx_brk_reg;
  // 16-bit baud counter gives the oversample tick
  wire logic tick = (brg_reg <= 16'h0001);
  wire logic tx_bit_end = tick && (tx_sub_reg == URM_OVERSAMPLE);
  wire logic rx_mid = tick && (rx_sub_reg == 4'h7);
  always_ff @(posedge clk_in) begin
    if (rst_in || tick) brg_reg <= divisor_in;
    else brg_reg <= brg_reg - 16'h0001;
  end
  // Transmit shifter, LSB first
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tx_cnt_reg <= 4'h0;
      tx_sub_reg <= 4'h0;
      tx_sh_reg <= 10'h3FF;
    end else if (tx_load_in && tx_cnt_reg == 4'h0) begin
      tx_sh_reg <= {1'b1, tx_byte_in, 1'b0};
      tx_cnt_reg <= URM_FRAME_BITS;
      tx_sub_reg <= 4'h0;
    end else if (tx_cnt_reg != 4'h0 && tick) begin
      tx_sub_reg <= tx_sub_reg + 4'h1;
      if (tx_bit_end) begin
        tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
        tx_cnt_reg <= tx_cnt_reg - 4'h1;
      end
    end
  end
  // Receive shifter, samples mid-bit
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rx_act_reg <= 1'b0;
      rx_sub_reg <= 4'h0;
      rx_cnt_reg <= 4'h0;
      rx_sh_reg <= 9'h000;
      rx_done_reg <= 1'b0;
      rx_brk_reg <= 1'b0;
    end else begin
      rx_done_reg <= 1'b0;
      if (!rx_act_reg) begin
        rx_sub_reg <= 4'h0;
        rx_cnt_reg <= 4'h0;
        if (!rx_line_in) rx_act_reg <= 1'b1;
      end else if (tick) begin
        rx_sub_reg <= rx_sub_reg + 4'h1;
        if (rx_mid) begin
          rx_sh_reg <= {rx_line_in, rx_sh_reg[8:1]};
          rx_cnt_reg <= rx_cnt_reg + 4'h1;
          if (rx_cnt_reg == 4'h0 && rx_line_in) rx_act_reg <= 1'b0;
          if (rx_cnt_reg == URM_FRAME_BITS - 4'h1) begin
            rx_act_reg <= 1'b0;
            rx_done_reg <= 1'b1;
            rx_brk_reg <= ~rx_line_in && (rx_sh_reg[8:1] == 8'h00);
          end
        end
      end
    end
  end
  assign tx_line_out = tx_sh_reg[0];
  assign tx_busy_out = (tx_cnt_reg != 4'h0);
  assign rx_done_out = rx_done_reg;
  // Stop bit sits in the top place once the frame is in, data below it
  assign rx_byte_out = rx_sh_reg[7:0];
  assign rx_break_out = rx_brk_reg;
endmodule // urm_serial
`default_nettype wire

//--- src/urm_top.sv
// Overview of operation
// - modem control bit 4 selects loopback
// - all functions but break keep running during loopback
// - transmit shift output feeds receive shifter
// - transmit and request outputs held high
// - receive and clear-to-send pins ignored
// - access only with chip select, bank-decoded
// - address 0 is receive/transmit holding
// - divisor enable maps divisor bytes
// - zero divisor exposes revision and identity
// - address 1 is interrupt enable
// - address 2 is status/fifo control
// - line control readable in every bank
// - addresses 4-7 modem, line, status, scratch
// - key bank maps enhanced and flow chars
// - enhanced bits gated by enhanced enable
// - 16-bit baud divisor via latch bytes
`timescale 1ns/10ps
`default_nettype none
module urm_top #(
  parameter logic [7:0] REVISION = 8'h5A, // Arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h3C // Arbitrary value
) (
  input wire logic clk_in, // 40 MHz system clock
  input wire logic rst_in, // Synchronous reset, active high
  input wire urm_pkg::urm_bus_type bus_in, // Host bus request
  input wire logic rx_pin_in, // Serial receive pin
  input wire logic cts_n_in, // Clear to send, active low
  input wire logic dsr_n_in, // Data set ready, active low
  input wire logic cd_n_in, // Carrier detect, active low
  input wire logic ri_n_in, // Ring indicator, active low
  output logic [7:0] rdata_out, // Read data, registered
  output logic tx_pin_out, // Serial transmit pin
  output logic rts_n_out, // Request to send, active low
  output logic dtr_n_out, // Data terminal ready, active low
  output logic loop_out // Loopback active
);
  import urm_pkg::*;

  logic [7:0] rhr_reg;
  logic [7:0] ier_reg;
  logic [7:0] fcr_reg;
  logic [7:0] lcr_reg;
  logic [7:0] mcr_reg;
  logic [7:0] spr_reg;
  logic [7:0] efr_reg;
  logic [15:0] div_reg;
  logic [7:0] xon1_reg;
  logic [7:0] xon2_reg;
  logic [7:0] xoff1_reg;
  logic [7:0] xoff2_reg;
  logic rdy_reg;
  logic ovr_reg;
  logic brk_reg;
  logic [3:0] dmsr_reg;
  logic [3:0] mprev_reg;
  logic rd_prev_reg;
  logic [7:0] rdata_reg;
  logic tx_pin_reg;
  logic rts_n_reg;
  logic dtr_n_reg;
  logic loop_reg;
  logic [7:0] rdata_next;

  // Pin synchronisers, idle levels high
  logic rx_sync;
  logic [3:0] mpin_sync;
  urm_sync #(.WIDTH(1), .INIT(1'b1)) u_rx_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in(rx_pin_in),
    .level_out(rx_sync)
  );
  urm_sync #(.WIDTH(4), .INIT(4'hF)) u_modem_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in({cd_n_in, ri_n_in, dsr_n_in, cts_n_in}),
    .level_out(mpin_sync)
  );

  // Bank decoding
  // chip select qualifies
  wire logic acc_rd = bus_in.cs && bus_in.rd;
  wire logic acc_wr = bus_in.cs && bus_in.wr;
  wire logic div_en = lcr_reg[URM_LCR_DIVEN_BIT];
  wire logic key_bank = (lcr_reg == URM_ENH_KEY);
  wire logic enh_on = efr_reg[URM_EFR_ENH_BIT];
  wire logic [2:0] a = bus_in.addr;
  wire logic loop_on = mcr_reg[URM_MCR_LOOP_BIT];

  // Write strobes per register
  // holding register write
  wire logic wr_thr = acc_wr && a == URM_ADDR_DATA && !div_en && !key_bank;
  wire logic wr_dll = acc_wr && a == URM_ADDR_DATA && div_en;
  wire logic wr_dlm = acc_wr && a == URM_ADDR_IEN && div_en;
  wire logic wr_ier = acc_wr && a == URM_ADDR_IEN && !div_en && !key_bank;
  wire logic wr_fcr = acc_wr && a == URM_ADDR_ISTF && !key_bank;
  wire logic wr_efr = acc_wr && a == URM_ADDR_ISTF && key_bank;
  wire logic wr_xon1 = acc_wr && a == URM_ADDR_MCTL && key_bank;
  wire logic wr_xon2 = acc_wr && a == URM_ADDR_LSTS && key_bank;
  wire logic wr_xoff1 = acc_wr && a == URM_ADDR_MSTS && key_bank;
  wire logic wr_xoff2 = acc_wr && a == URM_ADDR_SCR && key_bank;
  wire logic wr_lcr = acc_wr && a == URM_ADDR_LCTL;
  wire logic wr_mcr = acc_wr && a == URM_ADDR_MCTL && !key_bank;
  wire logic wr_spr = acc_wr && a == URM_ADDR_SCR && !key_bank;

  // Enhanced bit gating
  // mask enhanced bits
  wire logic [7:0] ier_mask = enh_on ? 8'hFF : ~URM_IER_ENH_MASK;
  wire logic [7:0] fcr_mask = enh_on ? 8'hFF : ~URM_FCR_ENH_MASK;
  wire logic [7:0] isr_mask = enh_on ? 8'hFF : ~URM_ISR_ENH_MASK;
  wire logic [7:0] mcr_mask = enh_on ? 8'hFF : ~URM_MCR_ENH_MASK;
  wire logic [7:0] ier_vis = ier_reg & ier_mask;
  wire logic [7:0] mcr_vis = mcr_reg & mcr_mask;

  // Serial path and loopback routing
  logic ser_tx;
  logic ser_busy;
  logic ser_done;
  logic [7:0] ser_byte;
  logic ser_brk;
  wire logic rx_src = loop_on ? ser_tx : rx_sync;
  urm_serial u_serial (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .divisor_in(div_reg),
    .tx_load_in(wr_thr),
    .tx_byte_in(bus_in.wdata),
    .rx_line_in(rx_src),
    .tx_line_out(ser_tx),
    .tx_busy_out(ser_busy),
    .rx_done_out(ser_done),
    .rx_byte_out(ser_byte),
    .rx_break_out(ser_brk)
  );

  // Modem status inputs, loopback feeds from control bits
  // clear-to-send ignored in loopback
  wire logic [3:0] mpin_act = ~mpin_sync;
  wire logic [3:0] mloop = {mcr_reg[3], mcr_reg[2], mcr_reg[0], mcr_reg[1]};
  wire logic [3:0] mstat = loop_on ? mloop : mpin_act;
  wire logic [7:0] msr_vis = {mstat, dmsr_reg};

  // Status register views
  wire logic [7:0] lsr_vis = {1'b0, ~ser_busy, ~ser_busy, brk_reg, 2'b00,
    ovr_reg, rdy_reg};
  wire logic fifo_on = fcr_reg[0];
  wire logic [7:0] isr_vis = ({fifo_on, fifo_on, 6'h00} | URM_ISR_NONE)
    & isr_mask;
  wire logic div_zero = (div_reg == 16'h0000);

  // Read data selection
  // bank and address select read data
  always_comb begin
    rdata_next = 8'h00;
    if (a == URM_ADDR_LCTL) begin
      rdata_next = lcr_reg;
    end else if (div_en && !key_bank && a == URM_ADDR_DATA) begin
      rdata_next = div_zero ? REVISION : div_reg[7:0];
    end else if (div_en && !key_bank && a == URM_ADDR_IEN) begin
      rdata_next = div_zero ? DEVICE_ID : div_reg[15:8];
    end else if (key_bank && a == URM_ADDR_ISTF) begin
      rdata_next = efr_reg;
    end else if (key_bank && (a == URM_ADDR_DATA || a == URM_ADDR_IEN)) begin
      rdata_next = (a == URM_ADDR_DATA) ? div_reg[7:0] : div_reg[15:8];
    end else if (key_bank) begin
      rdata_next = 8'h00;
    end else if (a == URM_ADDR_DATA) begin
      rdata_next = rhr_reg;
    end else if (a == URM_ADDR_IEN) begin
      rdata_next = ier_vis;
    end else if (a == URM_ADDR_ISTF) begin
      rdata_next = isr_vis;
    end else if (a == URM_ADDR_MCTL) begin
      rdata_next = mcr_vis;
    end else if (a == URM_ADDR_LSTS) begin
      rdata_next = lsr_vis;
    end else if (a == URM_ADDR_MSTS) begin
      rdata_next = msr_vis;
    end else begin
      rdata_next = spr_reg;
    end
  end

  // Read strobe edges used for read side effects
  wire logic rd_edge = acc_rd && !rd_prev_reg;
  wire logic rd_rhr = rd_edge && a == URM_ADDR_DATA && !div_en && !key_bank;
  wire logic rd_lsr = rd_edge && a == URM_ADDR_LSTS && !key_bank;
  wire logic rd_msr = rd_edge && a == URM_ADDR_MSTS && !key_bank;
  wire logic [3:0] mdelta = {mstat[3] ^ mprev_reg[3], ~mstat[2] & mprev_reg[2],
    mstat[1:0] ^ mprev_reg[1:0]};

  // Host-written control registers
  // divisor latch bytes
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      div_reg <= URM_RST_DIV;
      lcr_reg <= URM_RST_LCR;
      ier_reg <= URM_RST_BYTE;
      fcr_reg <= URM_RST_BYTE;
      mcr_reg <= URM_RST_BYTE;
      spr_reg <= URM_RST_BYTE;
      efr_reg <= URM_RST_BYTE;
    end else begin
      if (wr_dll) div_reg[7:0] <= bus_in.wdata;
      if (wr_dlm) div_reg[15:8] <= bus_in.wdata;
      if (wr_lcr) lcr_reg <= bus_in.wdata;
      if (wr_ier) ier_reg <= bus_in.wdata & ier_mask;
      if (wr_fcr) fcr_reg <= bus_in.wdata & fcr_mask;
      if (wr_mcr) mcr_reg <= bus_in.wdata & mcr_mask;
      if (wr_spr) spr_reg <= bus_in.wdata;
      if (wr_efr) efr_reg <= bus_in.wdata;
    end
  end

  // Flow control characters
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      xon1_reg <= URM_RST_BYTE;
      xon2_reg <= URM_RST_BYTE;
      xoff1_reg <= URM_RST_BYTE;
      xoff2_reg <= URM_RST_BYTE;
    end else begin
      if (wr_xon1) xon1_reg <= bus_in.wdata;
      if (wr_xon2) xon2_reg <= bus_in.wdata;
      if (wr_xoff1) xoff1_reg <= bus_in.wdata;
      if (wr_xoff2) xoff2_reg <= bus_in.wdata;
    end
  end

  // Receive holding and line status; a new event beats the read clear
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rhr_reg <= URM_RST_BYTE;
      rdy_reg <= 1'b0;
      ovr_reg <= 1'b0;
      brk_reg <= 1'b0;
      rd_prev_reg <= 1'b0;
    end else begin
      rd_prev_reg <= acc_rd;
      if (ser_done) begin
        rhr_reg <= ser_byte;
        rdy_reg <= 1'b1;
      end else if (rd_rhr) begin
        rdy_reg <= 1'b0;
      end
      if (ser_done && rdy_reg && !rd_rhr) ovr_reg <= 1'b1;
      else if (rd_lsr) ovr_reg <= 1'b0;
      if (ser_done && ser_brk) brk_reg <= 1'b1;
      else if (rd_lsr) brk_reg <= 1'b0;
    end
  end

  // Modem status deltas, set wins over read clear
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mprev_reg <= 4'h0;
      dmsr_reg <= 4'h0;
    end else begin
      mprev_reg <= mstat;
      dmsr_reg <= mdelta | (rd_msr ? 4'h0 : dmsr_reg);
    end
  end

  // Registered pin drivers and read data
  // outputs held high in loopback
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tx_pin_reg <= 1'b1;
      rts_n_reg <= 1'b1;
      dtr_n_reg <= 1'b1;
      loop_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      tx_pin_reg <= loop_on | (ser_tx & ~lcr_reg[6]);
      rts_n_reg <= loop_on | ~mcr_reg[URM_MCR_RTS_BIT];
      dtr_n_reg <= loop_on | ~mcr_reg[0];
      loop_reg <= loop_on;
      if (acc_rd) rdata_reg <= rdata_next;
    end
  end

  assign rdata_out = rdata_reg;
  assign tx_pin_out = tx_pin_reg;
  assign rts_n_out = rts_n_reg;
  assign dtr_n_out = dtr_n_reg;
  assign loop_out = loop_reg;
endmodule // urm_top
`default_nettype wire

//--- test/urm_chk.sv
`timescale 1ns/10ps
`default_nettype none
// Watches the host bus and the modem outputs of the register block
module urm_chk (
  input wire logic clk_in, // System clock
  input wire logic rst_in, // Synchronous reset
  input wire urm_pkg::urm_bus_type bus_in, // Host bus request
  input wire logic rx_pin_in, // Serial receive pin
  input wire logic cts_n_in, // Clear to send
  input wire logic dsr_n_in, // Data set ready
  input wire logic cd_n_in, // Carrier detect
  input wire logic ri_n_in, // Ring indicator
  input wire logic [7:0] rdata_out, // Read data
  input wire logic tx_pin_out, // Serial transmit pin
  input wire logic rts_n_out, // Request to send
  input wire logic dtr_n_out, // Data terminal ready
  input wire logic loop_out // Loopback active
);
  import urm_pkg::*;
  logic [7:0] lctl_reg;
  logic [7:0] mctl_reg;
  // Decoded host strobes
  wire wr_hit = bus_in.cs && bus_in.wr;
  wire rd_hit = bus_in.cs && bus_in.rd && !bus_in.wr;
  wire key_bank = (lctl_reg == URM_ENH_KEY);
  // Shadow copies of line and modem control
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      lctl_reg <= URM_RST_LCR;
      mctl_reg <= URM_RST_BYTE;
    end else if (wr_hit && bus_in.addr == URM_ADDR_LCTL) begin
      lctl_reg <= bus_in.wdata;
    end else if (wr_hit && bus_in.addr == URM_ADDR_MCTL && !key_bank) begin
      mctl_reg <= bus_in.wdata;
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  // Modem control write and a read of one place
  sequence mctl_wr_s;
    wr_hit && bus_in.addr == URM_ADDR_MCTL && !key_bank;
  endsequence
  sequence rd_at_s(logic [2:0] a);
    rd_hit && bus_in.addr == a;
  endsequence
  loop_enter_a: assert property (mctl_wr_s ##0 bus_in.wdata[4] |-> ##2 loop_out)
    else $error("loopback not entered");
  loop_leave_a: assert property (mctl_wr_s ##0 !bus_in.wdata[4] |-> ##2 !loop_out)
    else $error("loopback not left");
  loop_pins_a: assert property (loop_out |-> tx_pin_out && rts_n_out)
    else $error("pins not high in loopback");
  rts_follow_a: assert property (!loop_out && !$past(rst_in)
    |-> rts_n_out == !$past(mctl_reg[1]))
    else $error("request output not under control");
  rdata_hold_a: assert property (!(bus_in.cs && bus_in.rd) && !rst_in
    |=> $stable(rdata_out))
    else $error("read data moved without a read");
  lctl_read_a: assert property (rd_at_s(URM_ADDR_LCTL) |=> rdata_out == $past(lctl_reg))
    else $error("line control read wrong");
  key_wo_a: assert property (rd_hit && key_bank && bus_in.addr >= 3'h5 |=> rdata_out == 8'h00)
    else $error("write-only place read back");
  ists_read_a: assert property (rd_at_s(URM_ADDR_ISTF) ##0 !key_bank |=> rdata_out[3:0] == 4'h1)
    else $error("interrupt status wrong");
  msts_loop_a: assert property (loop_out ##0 rd_at_s(URM_ADDR_MSTS) ##0 !key_bank
    |=> rdata_out[5:4] == {mctl_reg[0], mctl_reg[1]})
    else $error("modem status not from modem control");
endmodule // urm_chk

bind urm_top urm_chk urm_chk_inst (.clk_in(clk_in), .rst_in(rst_in),
  .bus_in(bus_in), .rx_pin_in(rx_pin_in), .cts_n_in(cts_n_in),
  .dsr_n_in(dsr_n_in), .cd_n_in(cd_n_in), .ri_n_in(ri_n_in),
  .rdata_out(rdata_out), .tx_pin_out(tx_pin_out), .rts_n_out(rts_n_out),
  .dtr_n_out(dtr_n_out), .loop_out(loop_out));
`default_nettype wire

//--- test/urm_peer.sv
`timescale 1ns/10ps
`default_nettype none
// Far end of the serial line and modem pins
module urm_peer (
  input wire logic clk_in, // System clock
  input wire logic loop_in, // Device is looping back
  input wire logic tx_in, // Device transmit pin
  output logic rx_out, // Device receive pin
  output logic cts_n_out, // Clear to send
  output logic dsr_n_out, // Data set ready
  output logic cd_n_out, // Carrier detect
  output logic ri_n_out // Ring indicator
);
  logic [3:0] wiggle_reg = 4'h0;
  // Modem lines keep moving so an ignored input would show
  always_ff @(posedge clk_in) begin
    wiggle_reg <= wiggle_reg + 4'h1;
  end
  assign {cd_n_out, ri_n_out, dsr_n_out, cts_n_out} = wiggle_reg;
  // idle during loopback, otherwise a wire echo
  assign rx_out = loop_in ? 1'b1 : tx_in;
endmodule // urm_peer
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) begin num_checks++; if ((got) !== (exp)) begin \
  fails++; $display("BAD %s expected %h seen %h", what, exp, got); end end
// Self-checking bench for the register block and its loopback path
module tb_top;
  import urm_pkg::*;
  localparam logic [7:0] REV = 8'hA7; // Arbitrary value
  localparam logic [7:0] DID = 8'h29; // Arbitrary value
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  urm_bus_type bus_reg = '0;
  wire logic rx_w, cts_w, dsr_w, cd_w, ri_w, tx_w, rts_w, dtr_w, loop_w;
  wire logic [7:0] rdata_w;
  int fails = 0;
  int num_checks = 0;
  logic [31:0] seed_reg = 32'h916AB6DF;
  // Clock at 40 MHz
  always #12.5 clk_in = ~clk_in;
  urm_top #(.REVISION(REV), .DEVICE_ID(DID)) urm_top_inst (.clk_in(clk_in),
    .rst_in(rst_in), .bus_in(bus_reg), .rx_pin_in(rx_w), .cts_n_in(cts_w),
    .dsr_n_in(dsr_w), .cd_n_in(cd_w), .ri_n_in(ri_w), .rdata_out(rdata_w),
    .tx_pin_out(tx_w), .rts_n_out(rts_w), .dtr_n_out(dtr_w),
    .loop_out(loop_w));
  urm_peer urm_peer_inst (.clk_in(clk_in), .loop_in(loop_w), .tx_in(tx_w),
    .rx_out(rx_w), .cts_n_out(cts_w), .dsr_n_out(dsr_w), .cd_n_out(cd_w),
    .ri_n_out(ri_w));
  // Random bytes and expectations
  task automatic next_rand(output logic [7:0] v);
    seed_reg = seed_reg ^ (seed_reg << 13);
    seed_reg = seed_reg ^ (seed_reg >> 17);
    seed_reg = seed_reg ^ (seed_reg << 5);
    v = seed_reg[7:0];
  endtask
  function automatic logic [7:0] ien_exp(input logic [7:0] v, input logic e);
    return e ? v : (v & ~URM_IER_ENH_MASK);
  endfunction
  // Host bus cycles, one edge each
  task automatic bus_wr(input logic [2:0] a, input logic [7:0] d,
                        input logic sel);
    @(posedge clk_in);
    bus_reg <= '{cs: sel, rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk_in);
    bus_reg <= '0;
  endtask
  task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_in);
    bus_reg <= '{cs: 1'b1, rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(posedge clk_in);
    bus_reg <= '0;
    #1;
    d = rdata_w;
  endtask
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e,
                        input string what);
    logic [7:0] v;
    bus_rd(a, v);
    `CHK(what, e, v)
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Poll for a received byte with a bound
  task automatic wait_ready();
    logic [7:0] s;
    for (int n = 0; n < 200; n++) begin
      bus_rd(URM_ADDR_LSTS, s);
      if (s[0] === 1'b1) begin
        return;
      end
    end
    fails++;
    give_verdict();
  endtask
  task automatic send_chk(input logic [7:0] v);
    // Let the previous stop bit leave the shifter, it has no holding stage
    repeat (16) @(posedge clk_in);
    bus_wr(URM_ADDR_DATA, v, 1'b1);
    wait_ready();
    rd_chk(URM_ADDR_DATA, v, "receive_holding");
  endtask
  task automatic pins_chk(input logic lp, input logic rts);
    repeat (2) @(posedge clk_in);
    #1;
    `CHK("loop_out", lp, loop_w)
    `CHK("tx_pin_out", 1'b1, tx_w)
    `CHK("rts_n_out", rts, rts_w)
    `CHK("dtr_n_out", 1'b1, dtr_w)
  endtask
  // Watchdog
  initial begin
    repeat (60000) @(posedge clk_in);
    fails++;
    give_verdict();
  end
  // Main sequence
  initial begin
    logic [7:0] v, d0, d1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    rd_chk(URM_ADDR_LCTL, URM_RST_LCR, "line_control");
    bus_wr(URM_ADDR_LSTS, 8'hFF, 1'b1);
    rd_chk(URM_ADDR_LSTS, URM_LSR_TXE, "line_status");
    rd_chk(URM_ADDR_ISTF, URM_ISR_NONE, "interrupt_status");
    for (int i = 0; i < 8; i++) begin
      next_rand(v);
      next_rand(d0);
      bus_wr(URM_ADDR_SCR, v, 1'b1);
      bus_wr(URM_ADDR_SCR, d0, 1'b0);
      rd_chk(URM_ADDR_SCR, v, "scratchpad");
    end
    next_rand(v);
    bus_wr(URM_ADDR_IEN, v, 1'b1);
    rd_chk(URM_ADDR_IEN, ien_exp(v, 1'b0), "interrupt_enable");
    $display("done: plain bank");
    bus_wr(URM_ADDR_LCTL, 8'h83, 1'b1);
    rd_chk(URM_ADDR_DATA, URM_RST_DIV[7:0], "divisor_low_byte");
    rd_chk(URM_ADDR_IEN, URM_RST_DIV[15:8], "divisor_high_byte");
    next_rand(d0);
    next_rand(d1);
    d0 = d0 | 8'h01;
    bus_wr(URM_ADDR_DATA, d0, 1'b1);
    bus_wr(URM_ADDR_IEN, d1, 1'b1);
    rd_chk(URM_ADDR_DATA, d0, "divisor_low_byte");
    rd_chk(URM_ADDR_IEN, d1, "divisor_high_byte");
    bus_wr(URM_ADDR_DATA, 8'h00, 1'b1);
    bus_wr(URM_ADDR_IEN, 8'h00, 1'b1);
    rd_chk(URM_ADDR_DATA, REV, "revision_code");
    rd_chk(URM_ADDR_IEN, DID, "device_id_code");
    bus_wr(URM_ADDR_DATA, 8'h01, 1'b1);
    $display("done: divisor bank");
    bus_wr(URM_ADDR_LCTL, URM_ENH_KEY, 1'b1);
    rd_chk(URM_ADDR_LCTL, URM_ENH_KEY, "line_control");
    bus_wr(URM_ADDR_ISTF, 8'h10, 1'b1);
    rd_chk(URM_ADDR_ISTF, 8'h10, "enhanced_function");
    for (int i = 4; i < 8; i++) begin
      bus_wr(3'(i), 8'hA5, 1'b1);
    end
    rd_chk(URM_ADDR_SCR, 8'h00, "pause_char_second");
    bus_wr(URM_ADDR_LCTL, 8'h03, 1'b1);
    rd_chk(URM_ADDR_MCTL, 8'h00, "modem_control");
    next_rand(v);
    bus_wr(URM_ADDR_IEN, v, 1'b1);
    rd_chk(URM_ADDR_IEN, ien_exp(v, 1'b1), "interrupt_enable");
    $display("done: key bank");
    bus_wr(URM_ADDR_MCTL, 8'h13, 1'b1);
    pins_chk(1'b1, 1'b1);
    bus_rd(URM_ADDR_MSTS, v);
    `CHK("modem_status", 4'h3, v[7:4])
    next_rand(v);
    send_chk(8'h00);
    send_chk(8'hFF);
    send_chk(v);
    $display("done: loopback");
    bus_wr(URM_ADDR_MCTL, 8'h02, 1'b1);
    pins_chk(1'b0, 1'b0);
    send_chk(8'h5C);
    @(posedge clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    rd_chk(URM_ADDR_LCTL, URM_RST_LCR, "line_control");
    $display("done: exit and reset");
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
